// ---- hw/ascc_pkg.sv ----
// Shared constants and types for the sequencer conversion control block.
// Assumes a 32-bit APB register port and a single clock domain.
package ascc_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CONTROL = 12'h120;
  localparam logic [11:0] OFS_STATUS = 12'h124;
  localparam logic [11:0] OFS_TARGET = 12'h12c;
  localparam logic [11:0] OFS_COUNT = 12'h130;
  localparam logic [11:0] OFS_LEVEL = 12'h134;

  // Field layout
  localparam int CNT_W = 28;
  localparam int DATA_W = 32;
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_FRAME_BIT = 1;
  localparam int CTL_START_BIT = 2;
  localparam int STS_IDLE_BIT = 0;
  localparam int STS_ACTIVE_BIT = 2;
  localparam int STS_OVERRUN_BIT = 4;
  localparam int STS_PACING_BIT = 5;
  localparam int STS_FRAME_BIT = 6;
  localparam logic [CNT_W-1:0] TARGET_RESET = 28'h0000000;
  localparam logic [DATA_W-1:0] LEVEL_RESET = 32'h00000000;

  // Sample buffer
  localparam int SAMPLE_W = 16;
  localparam int SAMPLE_BYTES = 2;
  localparam int BUF_BYTES = 65536;
  localparam int BUF_WORDS = BUF_BYTES / SAMPLE_BYTES;
  localparam int BUF_AW = $clog2(BUF_WORDS);
  localparam logic [DATA_W-1:0] LEVEL_STEP = 32'h00000002;
  localparam logic [DATA_W-1:0] LEVEL_FULL = 32'h00010000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READY = 3'b001,
    ST_PULSE = 3'b010,
    ST_WAIT = 3'b011,
    ST_STORE = 3'b100,
    ST_STOP = 3'b101
  } ascc_state_e;

  typedef struct packed {
    logic frame_fault;
    logic pacing_fault;
    logic overrun;
    logic converting;
  } ascc_status_s;

endpackage

// ---- hw/ascc_sample_mem.sv ----
// Simple dual-port sample memory with registered read data.
// Assumes one clock; the caller never reads and writes the same word at once.
`timescale 1ns/1ps
module ascc_sample_mem #(
  parameter int WIDTH = 16,
  parameter int AW = 15
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ---- hw/ascc_seq_ctrl.sv ----
// Sequencer conversion control: event pacing, channel bursts, sample buffer, APB registers.
// Assumes tick and frame trigger pins are asynchronous; ADC data return on the same clock.
// Functional notes
// RULE1: 28-bit read/write target, upper bits zero
// RULE2: Each event converts every sequencer-mode device
// RULE3: Normal mode: events per start, zero continuous
// RULE4: Normal mode: target reached halts, clears converting
// RULE5: Frame mode: events per trigger, zero continuous
// RULE6: Frame mode: target reached halts until trigger
// RULE7: Channels start at zero, step upward
// RULE8: All devices step channels in lockstep
// RULE9: Samples per event equal summed channels
// RULE10: One conversion pulse per channel, all devices
// RULE11: Read-only 28-bit event counter
// RULE12: Event counter wraps to zero
// RULE13: Normal start clears event counter
// RULE14: Frame trigger clears counter unless fault
// RULE15: Read-only fill level in bytes, reset zero
// RULE16: 64 kB buffer, two bytes per sample
// RULE17: Early frame trigger flags fault and stops
// RULE18: Write into full buffer flags overrun, stops
// RULE19: Tick during busy event flags pacing fault
// RULE20: Converting set on start; never clears continuous
// RULE21: Level up two per sample, down per drain
`timescale 1ns/1ps
module ascc_seq_ctrl
  import ascc_pkg::*;
#(
  parameter int NDEV = 4,
  parameter int MAX_CH = 8,
  parameter int CH_W = $clog2(MAX_CH + 1)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pacing pins
  input wire logic seq_tick_pin,
  input wire logic frame_trigger_pin,
  // Device configuration
  input wire logic [NDEV-1:0] dev_seq_mode,
  input wire logic [NDEV-1:0][CH_W-1:0] dev_active_chans,
  // ADC conversion side
  output logic [NDEV-1:0] conv_pulse,
  output logic [CH_W-1:0] chan_index,
  input wire logic adc_data_valid,
  input wire logic [NDEV-1:0][SAMPLE_W-1:0] adc_data,
  // Buffer drain toward host memory
  output logic drain_valid,
  input wire logic drain_ready,
  output logic [SAMPLE_W-1:0] drain_data,
  // Status
  output logic input_unit_converting
);
  localparam int DEV_W = (NDEV > 1) ? $clog2(NDEV) : 1;
  localparam logic [DEV_W-1:0] LAST_DEV = DEV_W'(NDEV - 1);

  ascc_state_e state_reg, state_next;
  ascc_status_s status_reg, status_next;
  logic [2:0] tick_sync_reg, trig_sync_reg;
  logic ctl_enable_reg, ctl_enable_next, ctl_frame_reg, ctl_frame_next;
  logic [CNT_W-1:0] seq_event_target_reg, seq_event_target_next;
  logic [CNT_W-1:0] seq_event_counter_reg, seq_event_counter_next;
  logic [CH_W-1:0] ch_reg, ch_next;
  logic [DEV_W-1:0] dev_reg, dev_next;
  logic [NDEV-1:0][SAMPLE_W-1:0] data_reg, data_next;
  logic [NDEV-1:0] pulse_reg, pulse_next;
  logic [DATA_W-1:0] prdata_reg, prdata_next;
  logic slverr_reg, slverr_next;
  logic [CH_W-1:0] max_ch;
  logic tick_rise, trig_rise, wr_acc, start_req, buf_we, buf_full, part;
  logic [CNT_W-1:0] count_inc;
  // Buffer state
  logic [BUF_AW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [DATA_W-1:0] seq_buffer_fill_bytes_reg, seq_buffer_fill_bytes_next;
  logic pending_reg, pending_next, out_valid_reg, out_valid_next;
  logic rd_en, take;

  // Pin synchronisers; an edge counts when the second stage is high and the third still low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tick_sync_reg <= '0;
      trig_sync_reg <= '0;
    end else begin
      tick_sync_reg <= {tick_sync_reg[1:0], seq_tick_pin};
      trig_sync_reg <= {trig_sync_reg[1:0], frame_trigger_pin};
    end
  end
  assign tick_rise = tick_sync_reg[1] & ~tick_sync_reg[2];
  assign trig_rise = trig_sync_reg[1] & ~trig_sync_reg[2];

  assign wr_acc = psel & penable & pwrite;
  assign start_req = wr_acc && paddr == OFS_CONTROL && pwdata[CTL_START_BIT]
    && !ctl_frame_reg;
  assign buf_full = seq_buffer_fill_bytes_reg == LEVEL_FULL; // RULE16
  assign part = dev_seq_mode[dev_reg] && ch_reg < dev_active_chans[dev_reg];
  assign count_inc = seq_event_counter_reg + 1'b1; // RULE12

  // Longest channel count among sequencer-mode devices
  always_comb begin
    max_ch = '0;
    for (int d = 0; d < NDEV; d++) begin
      if (dev_seq_mode[d] && dev_active_chans[d] > max_ch) begin
        max_ch = dev_active_chans[d];
      end
    end
  end

  // Sequencer, registers and APB next values
  always_comb begin
    state_next = state_reg;
    status_next = status_reg;
    ctl_enable_next = ctl_enable_reg;
    ctl_frame_next = ctl_frame_reg;
    seq_event_target_next = seq_event_target_reg;
    seq_event_counter_next = seq_event_counter_reg;
    ch_next = ch_reg;
    dev_next = dev_reg;
    data_next = data_reg;
    pulse_next = '0;
    prdata_next = prdata_reg;
    slverr_next = slverr_reg;
    buf_we = 1'b0;
    if (wr_acc) begin
      if (paddr == OFS_CONTROL) begin
        ctl_enable_next = pwdata[CTL_ENABLE_BIT];
        ctl_frame_next = pwdata[CTL_FRAME_BIT];
      end else if (paddr == OFS_TARGET) begin
        seq_event_target_next = pwdata[CNT_W-1:0]; // RULE1
      end
    end
    if (psel && !penable) begin
      slverr_next = 1'b0;
      prdata_next = '0;
      unique case (paddr)
        OFS_CONTROL: begin
          prdata_next[CTL_ENABLE_BIT] = ctl_enable_reg;
          prdata_next[CTL_FRAME_BIT] = ctl_frame_reg;
        end
        OFS_STATUS: begin
          prdata_next[STS_IDLE_BIT] = state_reg == ST_READY && !status_reg.converting;
          prdata_next[STS_ACTIVE_BIT] = status_reg.converting;
          prdata_next[STS_OVERRUN_BIT] = status_reg.overrun;
          prdata_next[STS_PACING_BIT] = status_reg.pacing_fault;
          prdata_next[STS_FRAME_BIT] = status_reg.frame_fault;
        end
        OFS_TARGET: prdata_next[CNT_W-1:0] = seq_event_target_reg; // RULE1
        OFS_COUNT: prdata_next[CNT_W-1:0] = seq_event_counter_reg; // RULE11
        OFS_LEVEL: prdata_next = seq_buffer_fill_bytes_reg; // RULE15
        default: slverr_next = 1'b1;
      endcase
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (ctl_enable_reg) begin
          state_next = ST_READY;
        end
      end
      ST_READY: begin
        if (tick_rise && status_reg.converting) begin
          ch_next = '0; // RULE7
          if (max_ch == '0) begin
            seq_event_counter_next = count_inc;
            if (seq_event_target_reg != '0 && count_inc == seq_event_target_reg) begin
              status_next.converting = 1'b0;
            end
          end else begin
            state_next = ST_PULSE;
          end
        end
      end
      ST_PULSE: state_next = ST_WAIT;
      ST_WAIT: begin
        if (adc_data_valid) begin
          data_next = adc_data;
          dev_next = '0;
          state_next = ST_STORE;
        end
      end
      ST_STORE: begin
        if (part && buf_full) begin
          status_next.overrun = 1'b1; // RULE18
          status_next.converting = 1'b0;
          state_next = ST_STOP;
        end else begin
          buf_we = part; // RULE9
          dev_next = dev_reg + 1'b1;
          if (dev_reg == LAST_DEV) begin
            ch_next = ch_reg + 1'b1; // RULE7
            if (ch_reg + 1'b1 < max_ch) begin
              state_next = ST_PULSE;
            end else begin
              state_next = ST_READY;
              seq_event_counter_next = count_inc; // RULE11
              if (seq_event_target_reg != '0 && count_inc == seq_event_target_reg) begin
                status_next.converting = 1'b0; // RULE4 RULE6
              end
            end
          end
        end
      end
      ST_STOP: state_next = ST_STOP;
      default: state_next = ST_IDLE;
    endcase
    if (state_reg != ST_IDLE && state_reg != ST_STOP) begin
      if (tick_rise && (state_reg == ST_PULSE || state_reg == ST_WAIT
          || state_reg == ST_STORE)) begin
        status_next.pacing_fault = 1'b1; // RULE19
        status_next.converting = 1'b0;
        state_next = ST_STOP;
      end else if (ctl_frame_reg && trig_rise) begin
        if (status_reg.converting && seq_event_target_reg != '0) begin
          status_next.frame_fault = 1'b1; // RULE17
          status_next.converting = 1'b0;
          state_next = ST_STOP;
        end else begin
          status_next.converting = 1'b1; // RULE5 RULE20
          seq_event_counter_next = '0; // RULE14
        end
      end else if (start_req) begin
        status_next.converting = 1'b1; // RULE3 RULE20
        seq_event_counter_next = '0; // RULE13
      end
    end
    if (!ctl_enable_reg) begin
      state_next = ST_IDLE;
      status_next = '0;
    end
    if (state_next == ST_PULSE) begin
      for (int d = 0; d < NDEV; d++) begin
        pulse_next[d] = dev_seq_mode[d] && ch_next < dev_active_chans[d]; // RULE2 RULE10
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      status_reg <= '0;
      ctl_enable_reg <= 1'b0;
      ctl_frame_reg <= 1'b0;
      seq_event_target_reg <= TARGET_RESET;
      seq_event_counter_reg <= '0;
      ch_reg <= '0;
      dev_reg <= '0;
      data_reg <= '0;
      pulse_reg <= '0;
      prdata_reg <= '0;
      slverr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      status_reg <= status_next;
      ctl_enable_reg <= ctl_enable_next;
      ctl_frame_reg <= ctl_frame_next;
      seq_event_target_reg <= seq_event_target_next;
      seq_event_counter_reg <= seq_event_counter_next;
      ch_reg <= ch_next;
      dev_reg <= dev_next;
      data_reg <= data_next;
      pulse_reg <= pulse_next;
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  // Buffer pointers, prefetch stage and fill level
  assign take = out_valid_reg & drain_ready;
  assign rd_en = wr_ptr_reg != rd_ptr_reg && !pending_reg && (!out_valid_reg || drain_ready);
  always_comb begin
    wr_ptr_next = buf_we ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = rd_en ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    pending_next = rd_en;
    out_valid_next = pending_reg | (out_valid_reg & ~drain_ready);
    seq_buffer_fill_bytes_next = seq_buffer_fill_bytes_reg; // RULE21
    if (buf_we && !take) begin
      seq_buffer_fill_bytes_next = seq_buffer_fill_bytes_reg + LEVEL_STEP;
    end else if (take && !buf_we) begin
      seq_buffer_fill_bytes_next = seq_buffer_fill_bytes_reg - LEVEL_STEP;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      pending_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      seq_buffer_fill_bytes_reg <= LEVEL_RESET;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      pending_reg <= pending_next;
      out_valid_reg <= out_valid_next;
      seq_buffer_fill_bytes_reg <= seq_buffer_fill_bytes_next;
    end
  end

  ascc_sample_mem #(.WIDTH(SAMPLE_W), .AW(BUF_AW)) u_mem (
    .clock(clock),
    .reset(reset),
    .wr_en(buf_we),
    .wr_addr(wr_ptr_reg[BUF_AW-1:0]),
    .wr_data(data_reg[dev_reg]),
    .rd_en(rd_en),
    .rd_addr(rd_ptr_reg[BUF_AW-1:0]),
    .rd_data(drain_data)
  );

  assign prdata = prdata_reg;
  assign pready = psel & penable;
  assign pslverr = psel & penable & slverr_reg;
  assign conv_pulse = pulse_reg;
  assign chan_index = ch_reg; // RULE8
  assign drain_valid = out_valid_reg;
  assign input_unit_converting = status_reg.converting;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_target_read_upper: assert property ( // RULE1
    psel && !penable && !pwrite && paddr == OFS_TARGET |=> prdata[DATA_W-1:CNT_W] == '0
      && prdata[CNT_W-1:0] == $past(seq_event_target_reg))
    else $error("target read shows wrong bits");
  chk_pulse_lockstep: assert property ( // RULE8
    conv_pulse != '0 |-> state_reg == ST_PULSE
      && (conv_pulse & ~dev_seq_mode) == '0)
    else $error("pulse outside burst step or to idle device");
  chk_chan_start_zero: assert property ( // RULE7
    state_reg == ST_READY && state_next == ST_PULSE |=> chan_index == '0)
    else $error("event did not start at channel zero");
  chk_counter_wrap: assert property ( // RULE12
    state_reg == ST_STORE && state_next == ST_READY && !start_req && !trig_rise
      |=> seq_event_counter_reg == $past(seq_event_counter_reg) + 1'b1)
    else $error("event counter did not advance or wrap");
  chk_level_step: assert property ( // RULE21
    buf_we && !take |=> seq_buffer_fill_bytes_reg == $past(seq_buffer_fill_bytes_reg) + LEVEL_STEP)
    else $error("fill level did not rise by two bytes");
  chk_overrun_stop: assert property ( // RULE18
    state_reg == ST_STORE && part && buf_full && ctl_enable_reg
      |=> status_reg.overrun && state_reg == ST_STOP ##1 conv_pulse == '0)
    else $error("overrun did not stop the unit");
  chk_pacing_stop: assert property ( // RULE19
    state_reg == ST_WAIT && tick_rise && ctl_enable_reg
      |=> status_reg.pacing_fault && state_reg == ST_STOP)
    else $error("busy tick not flagged");
  chk_frame_fault: assert property ( // RULE17
    ctl_frame_reg && ctl_enable_reg && trig_rise && status_reg.converting
      && seq_event_target_reg != '0 && state_reg == ST_READY
      |=> status_reg.frame_fault && !status_reg.converting [*2])
    else $error("early frame trigger not flagged");
  chk_normal_clear: assert property ( // RULE13
    start_req && state_reg == ST_READY && ctl_enable_reg
      |=> seq_event_counter_reg == '0 && status_reg.converting)
    else $error("start did not clear counter");
  chk_target_halt: assert property ( // RULE4
    state_reg == ST_STORE && state_next == ST_READY && seq_event_target_reg != '0
      && count_inc == seq_event_target_reg && !tick_rise && !trig_rise && !start_req
      |=> !status_reg.converting)
    else $error("converting not cleared at target");
endmodule

// ---- sim/ascc_adc_model.sv ----
// Behavioural set of multiplexed SAR converters behind the sequencer.
// Assumes conv_pulse and chan_index come from the sequencer on the same clock.
`timescale 1ns/1ps
module ascc_adc_model
  import ascc_pkg::*;
#(
  parameter int NDEV = 4,
  parameter int CH_W = 4
) (
  // Clock and pulses
  input wire logic clock,
  input wire logic [NDEV-1:0] conv_pulse,
  input wire logic [CH_W-1:0] chan_index,
  input wire logic [7:0] delay,
  // Results
  output logic adc_data_valid,
  output logic [NDEV-1:0][SAMPLE_W-1:0] adc_data
);
  int wait_cnt = -1;
  logic [7:0] seq = 8'h00;
  initial adc_data_valid = 1'b0;
  initial adc_data = '0;
  always @(posedge clock) begin
    adc_data_valid <= 1'b0;
    // Released data bus shows inverted data, never the last result
    if (adc_data_valid)
      adc_data <= ~adc_data;
    if (|conv_pulse)
      wait_cnt = delay;
    else if (wait_cnt > 0)
      wait_cnt = wait_cnt - 1;
    if (wait_cnt == 0) begin
      wait_cnt = -1;
      adc_data_valid <= 1'b1;
      for (int d = 0; d < NDEV; d++)
        adc_data[d] <= {4'(d), 4'(chan_index), seq};
      seq <= seq + 8'h01;
    end
  end
endmodule

// ---- sim/test_ascc_seq_ctrl.sv ----
// Self-checking bench for the sequencer conversion control block.
// Assumes the converter model answers each pulse after a set delay.
`timescale 1ns/1ps
module test_ascc_seq_ctrl
  import ascc_pkg::*;
;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, valid, conv;
  logic drain_valid, drain_ready, drain_on, track;
  logic [1:0] pins;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] mode, conv_pulse, chan_index;
  logic [3:0][3:0] chans;
  logic [3:0][15:0] adc_data;
  logic [15:0] drain_data;
  logic [7:0] delay, seq;
  logic [64:0] e;
  logic [64:0] rq[$];
  logic [15:0] sq[$];
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int nsamp;

  ascc_seq_ctrl #(.NDEV(4), .MAX_CH(8)) uut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .seq_tick_pin(pins[0]), .frame_trigger_pin(pins[1]),
    .dev_seq_mode(mode), .dev_active_chans(chans), .conv_pulse(conv_pulse),
    .chan_index(chan_index), .adc_data_valid(valid), .adc_data(adc_data),
    .drain_valid(drain_valid), .drain_ready(drain_ready), .drain_data(drain_data),
    .input_unit_converting(conv));
  ascc_adc_model #(.NDEV(4), .CH_W(4)) adc (.clock(clock), .conv_pulse(conv_pulse),
    .chan_index(chan_index), .delay(delay), .adc_data_valid(valid), .adc_data(adc_data));

  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [3:0] pmask(logic [3:0] ch);
    for (int d = 0; d < 4; d++)
      pmask[d] = mode[d] && ch < chans[d];
  endfunction

  // Read expectations carry {slave error, compare mask, data}
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [64:0] x);
    if (!w)
      rq.push_back(x);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the cycle ceiling ends a wait for the answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] m, logic [31:0] v);
    apb(1'b0, a, 32'h0, {1'b0, m, v});
  endtask

  task automatic pulse_pin(int which, int gap);
    pins[which] <= 1'b1;
    repeat (4) @(posedge clock);
    pins[which] <= 1'b0;
    repeat (gap) @(posedge clock);
  endtask

  // One tick; when a conversion is expected and track is set its samples are noted in order
  task automatic event_go(int gap, logic expect_conv);
    int top;
    top = 0;
    for (int d = 0; d < 4; d++)
      if (mode[d] && chans[d] > top)
        top = chans[d];
    for (int c = 0; c < top && expect_conv; c++) begin
      for (int d = 0; d < 4; d++)
        if (mode[d] && c < chans[d] && track) begin
          sq.push_back({4'(d), 4'(c), seq});
          nsamp++;
        end
      seq++;
    end
    pulse_pin(0, gap);
  endtask

  task automatic drain_all();
    drain_on <= 1'b1;
    for (int i = 0; i < 3000 && sq.size() > 0; i++)
      @(posedge clock);
    repeat (4) @(posedge clock);
    rd(OFS_LEVEL, 32'hffffffff, 32'h0);
    drain_on <= 1'b0;
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    drain_ready <= drain_on && ($urandom % 3 != 0);
    if (psel && penable && pready && !pwrite && rq.size() > 0) begin
      e = rq.pop_front();
      check("apb read", 64'({pslverr, prdata & e[63:32]}), 64'({e[64], e[31:0]}));
    end
    if (drain_valid && drain_ready && track) begin
      if (sq.size() == 0)
        check("drain extra", 64'h1, 64'h0);
      else
        check("drain data", 64'(drain_data), 64'(sq.pop_front()));
    end
    if (|conv_pulse)
      check("pulse mask", 64'(conv_pulse), 64'(pmask(chan_index)));
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, drain_on, pins, seq, delay} = '0;
    {paddr, pwdata, mode, chans} = '0;
    track = 1'b1;
    nsamp = 0;
    void'($urandom(32'h9fcc));
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(OFS_TARGET, 32'hffffffff, 32'(TARGET_RESET));
    rd(OFS_COUNT, 32'hffffffff, 32'h0);
    rd(OFS_LEVEL, 32'hffffffff, LEVEL_RESET);
    apb(1'b0, 12'h200, 32'h0, {1'b1, 32'hffffffff, 32'h0});
    apb(1'b1, OFS_TARGET, 32'hffffffff, '0);
    rd(OFS_TARGET, 32'hffffffff, 32'h0fffffff);
    apb(1'b1, OFS_COUNT, 32'h5, '0);
    apb(1'b1, OFS_LEVEL, 32'h8, '0);
    rd(OFS_COUNT, 32'hffffffff, 32'h0);
    rd(OFS_LEVEL, 32'hffffffff, 32'h0);
    // Normal block of three events with random device set-up
    mode <= 4'($urandom) | 4'h1;
    for (int d = 0; d < 4; d++)
      chans[d] <= (d == 0) ? 4'(1 + $urandom % 8) : 4'($urandom % 9);
    delay <= 8'($urandom % 4);
    apb(1'b1, OFS_TARGET, 32'h3, '0);
    apb(1'b1, OFS_CONTROL, 32'h1, '0);
    apb(1'b1, OFS_CONTROL, 32'h5, '0);
    rd(OFS_STATUS, 32'h74, 32'h4);
    check("converting", 64'(conv), 64'h1);
    repeat (3) event_go(120, 1'b1);
    rd(OFS_STATUS, 32'h74, 32'h0);
    check("converting", 64'(conv), 64'h0);
    event_go(120, 1'b0);
    rd(OFS_COUNT, 32'hffffffff, 32'h3);
    rd(OFS_LEVEL, 32'hffffffff, 32'(2 * nsamp));
    drain_all();
    // Continuous run after a restart
    apb(1'b1, OFS_TARGET, 32'h0, '0);
    apb(1'b1, OFS_CONTROL, 32'h5, '0);
    rd(OFS_COUNT, 32'hffffffff, 32'h0);
    repeat (4) event_go(120, 1'b1);
    rd(OFS_STATUS, 32'h74, 32'h4);
    check("converting", 64'(conv), 64'h1);
    rd(OFS_COUNT, 32'hffffffff, 32'h4);
    drain_all();
    // Frame mode, then an early trigger
    apb(1'b1, OFS_CONTROL, 32'h0, '0);
    apb(1'b1, OFS_TARGET, 32'h2, '0);
    apb(1'b1, OFS_CONTROL, 32'h3, '0);
    pulse_pin(1, 12);
    rd(OFS_STATUS, 32'h74, 32'h4);
    repeat (2) event_go(120, 1'b1);
    rd(OFS_STATUS, 32'h74, 32'h0);
    rd(OFS_COUNT, 32'hffffffff, 32'h2);
    event_go(120, 1'b0);
    pulse_pin(1, 12);
    rd(OFS_COUNT, 32'hffffffff, 32'h0);
    event_go(120, 1'b1);
    pulse_pin(1, 12);
    rd(OFS_STATUS, 32'h74, 32'h40);
    check("converting", 64'(conv), 64'h0);
    rd(OFS_COUNT, 32'hffffffff, 32'h1);
    event_go(120, 1'b0);
    apb(1'b1, OFS_CONTROL, 32'h0, '0);
    rd(OFS_STATUS, 32'h74, 32'h0);
    drain_all();
    // Fill the whole buffer with drain stalled
    track <= 1'b0;
    mode <= 4'hf;
    chans <= {4{4'h8}};
    delay <= 8'h0;
    apb(1'b1, OFS_TARGET, 32'h0, '0);
    apb(1'b1, OFS_CONTROL, 32'h1, '0);
    apb(1'b1, OFS_CONTROL, 32'h5, '0);
    repeat (1026) event_go(72, 1'b1);
    rd(OFS_STATUS, 32'h74, 32'h10);
    rd(OFS_LEVEL, 32'hffffffff, LEVEL_FULL);
    // Second tick while a slow event is still converting
    apb(1'b1, OFS_CONTROL, 32'h0, '0);
    apb(1'b1, OFS_CONTROL, 32'h1, '0);
    apb(1'b1, OFS_CONTROL, 32'h5, '0);
    delay <= 8'd20;
    event_go(10, 1'b1);
    event_go(400, 1'b1);
    rd(OFS_STATUS, 32'h74, 32'h20);
    repeat (4) @(posedge clock);
    results();
  end
endmodule
